// *** cdsf_pkg.sv ***
// Purpose: Shared constants for the per-channel diagnostic status machine
// Assumes: Status codes are 3 bits per channel
// Notes:   Codes are fixed by the status encoding
package cdsf_pkg;
	localparam logic [2:0] CDSF_ST_LATCHED  = 3'h0;
	localparam logic [2:0] CDSF_ST_BATT     = 3'h1;
	localparam logic [2:0] CDSF_ST_GND      = 3'h2;
	localparam logic [2:0] CDSF_ST_OPEN     = 3'h3;
	localparam logic [2:0] CDSF_ST_DONE     = 3'h4;
	localparam logic [2:0] CDSF_ST_NO_BATT  = 3'h5;
	localparam logic [2:0] CDSF_ST_NO_OFF   = 3'h6;
	localparam logic [2:0] CDSF_ST_NOT_DONE = 3'h7;
	localparam int         CDSF_CODE_W      = 3;
	localparam int         CDSF_SYNC_W      = 2;
endpackage

// *** cdsf_top.sv ***
// Purpose: Per-channel 3-bit priority-encoded diagnostic status state machine
// Assumes: Diagnostic results arrive as one-cycle pulses from timer logic
//          on clk_sys; core enable, input and supply levels are async pins
// Notes:   Pulse logic marks completion only after blanking/filter timers
`timescale 1ns/10ps
module cdsf_top #(
	parameter int NCH = 6
) (
	input  wire logic                   clk_sys,
	input  wire logic                   srst,
	input  wire logic                   por_ok,
	input  wire logic                   master_reset_n,
	input  wire logic                   output_enable_n,
	input  wire logic                   load_supply_ok,
	input  wire logic [NCH-1:0]         channel_parallel_input,
	input  wire logic [NCH-1:0]         channel_serial_gate_bit,
	input  wire logic [NCH-1:0]         latch_off_mode,
	input  wire logic [NCH-1:0]         on_pulse_req,
	input  wire logic [NCH-1:0]         off_pulse_req,
	input  wire logic [NCH-1:0]         unlatch,
	input  wire logic                   status_read,
	input  wire logic [NCH-1:0]         diag_done,
	input  wire logic [NCH-1:0]         short_to_battery,
	input  wire logic [NCH-1:0]         short_to_ground,
	input  wire logic [NCH-1:0]         open_load_fault,
	input  wire logic [NCH-1:0]         on_clean,
	input  wire logic [NCH-1:0]         off_clean,
	output logic      [3*NCH-1:0]       status_code,
	output logic      [NCH-1:0]         on_diag_start,
	output logic      [NCH-1:0]         off_diag_start,
	output logic                        uv_recover,
	output logic                        core_active
);
	initial begin
		if (NCH < 1 || NCH > 16) $error("cdsf_top: NCH out of range");
	end

	localparam int SW = cdsf_pkg::CDSF_SYNC_W;
	localparam int LW = 3 + 2 * NCH;

	// Two-flop synchronisers for pins: {por & rst_n, en_n, load_ok, in, gate}
	logic [LW-1:0] pin_raw;
	logic [LW-1:0] s1_r, s2_r, s1_nxt, s2_nxt;
	logic [LW-1:0] prev_r, prev_nxt;
	assign pin_raw = {por_ok & master_reset_n, output_enable_n, load_supply_ok,
		channel_parallel_input, channel_serial_gate_bit};
	always_comb begin
		s1_nxt   = pin_raw;
		s2_nxt   = s1_r;
		prev_nxt = s2_r;
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s1_r   <= '0;
			s2_r   <= '0;
			prev_r <= '0;
		end else begin
			s1_r   <= s1_nxt;
			s2_r   <= s2_nxt;
			prev_r <= prev_nxt;
		end
	end

	logic           live, en_n, en_n_q, ld_ok, ld_ok_q;
	logic [NCH-1:0] in_s, in_q, g_s, g_q;
	assign live    = s2_r[LW-1];
	assign en_n    = s2_r[LW-2];
	assign en_n_q  = prev_r[LW-2];
	assign ld_ok   = s2_r[LW-3];
	assign ld_ok_q = prev_r[LW-3];
	assign in_s    = s2_r[2*NCH-1:NCH];
	assign in_q    = prev_r[2*NCH-1:NCH];
	assign g_s     = s2_r[NCH-1:0];
	assign g_q     = prev_r[NCH-1:0];

	logic en_fall, en_rise;
	assign en_fall = en_n_q & ~en_n;
	assign en_rise = ~en_n_q & en_n;

	// Per-channel state and pending-fault hold for read collisions
	logic [2:0]     code_r   [NCH];
	logic [2:0]     code_nxt [NCH];
	logic [NCH-1:0] pend_b_r, pend_g_r, pend_o_r, pend_on_r, pend_off_r;
	logic [NCH-1:0] pend_b_nxt, pend_g_nxt, pend_o_nxt, pend_on_nxt, pend_off_nxt;
	logic [NCH-1:0] ons_nxt, offs_nxt;
	logic           uvr_nxt;

	always_comb begin
		logic b, g, o, onc, offc, pulse;
		logic [2:0] c;
		b = 1'b0;
		g = 1'b0;
		o = 1'b0;
		onc = 1'b0;
		offc = 1'b0;
		pulse = 1'b0;
		c = cdsf_pkg::CDSF_ST_NOT_DONE;
		// Needs live a cycle earlier too: no false recovery just after reset
		uvr_nxt = live & prev_r[LW-1] & ld_ok & ~ld_ok_q;
		for (int i = 0; i < NCH; i++) begin
			ons_nxt[i]  = live & ((en_fall & (in_s[i] | g_s[i]))
				| (~en_n & ~(in_q[i] | g_q[i]) & (in_s[i] | g_s[i]))
				| (~en_n & on_pulse_req[i]));
			offs_nxt[i] = live & ld_ok & ((en_fall & ~in_s[i] & ~g_s[i])
				| (~en_n & in_q[i] & ~in_s[i] & ~g_s[i])
				| (~en_n & g_q[i] & ~g_s[i] & ~in_s[i])
				| (~en_n & off_pulse_req[i]));
			// Results count only with diag_done, i.e. after timers end
			b    = (diag_done[i] & short_to_battery[i]) | pend_b_r[i];
			g    = (diag_done[i] & short_to_ground[i] & ld_ok) | pend_g_r[i];
			o    = (diag_done[i] & open_load_fault[i] & ld_ok) | pend_o_r[i];
			onc  = (diag_done[i] & on_clean[i]) | pend_on_r[i];
			offc = (diag_done[i] & off_clean[i] & ld_ok) | pend_off_r[i];
			pulse = on_pulse_req[i] | off_pulse_req[i];
			c = code_r[i];
			pend_b_nxt[i] = 1'b0;
			pend_g_nxt[i] = 1'b0;
			pend_o_nxt[i] = 1'b0;
			pend_on_nxt[i] = 1'b0;
			pend_off_nxt[i] = 1'b0;
			if (status_read) begin
				// Read first; fresh results held one cycle
				pend_b_nxt[i] = b;
				pend_g_nxt[i] = g;
				pend_o_nxt[i] = o;
				pend_on_nxt[i] = onc;
				pend_off_nxt[i] = offc;
				if (code_r[i] == cdsf_pkg::CDSF_ST_BATT && latch_off_mode[i])
					c = cdsf_pkg::CDSF_ST_LATCHED;
				else if (code_r[i] != cdsf_pkg::CDSF_ST_LATCHED)
					c = cdsf_pkg::CDSF_ST_NOT_DONE;
			end else begin
				unique case (code_r[i])
					cdsf_pkg::CDSF_ST_LATCHED: begin
						// Held until unlatch, enable re-cycle or pulse
						if (pulse | unlatch[i] | en_rise) c = cdsf_pkg::CDSF_ST_NOT_DONE;
					end
					cdsf_pkg::CDSF_ST_BATT: ;
					cdsf_pkg::CDSF_ST_GND: begin
						if (b) c = cdsf_pkg::CDSF_ST_BATT;
					end
					cdsf_pkg::CDSF_ST_OPEN: begin
						if (b) c = cdsf_pkg::CDSF_ST_BATT;
						else if (g) c = cdsf_pkg::CDSF_ST_GND;
					end
					cdsf_pkg::CDSF_ST_DONE, cdsf_pkg::CDSF_ST_NO_BATT,
					cdsf_pkg::CDSF_ST_NO_OFF: begin
						if (b) c = cdsf_pkg::CDSF_ST_BATT;
						else if (g) c = cdsf_pkg::CDSF_ST_GND;
						else if (o) c = cdsf_pkg::CDSF_ST_OPEN;
						else if ((code_r[i] == cdsf_pkg::CDSF_ST_NO_BATT && offc) ||
							(code_r[i] == cdsf_pkg::CDSF_ST_NO_OFF && onc))
							c = cdsf_pkg::CDSF_ST_DONE;
					end
					cdsf_pkg::CDSF_ST_NOT_DONE: begin
						if (!en_n) begin
							if (b) c = cdsf_pkg::CDSF_ST_BATT;
							else if (g) c = cdsf_pkg::CDSF_ST_GND;
							else if (o) c = cdsf_pkg::CDSF_ST_OPEN;
							else if (onc) c = cdsf_pkg::CDSF_ST_NO_BATT;
							else if (offc) c = cdsf_pkg::CDSF_ST_NO_OFF;
						end
					end
				endcase
			end
			if (!live) begin
				c = cdsf_pkg::CDSF_ST_NOT_DONE;
				pend_b_nxt[i] = 1'b0;
				pend_g_nxt[i] = 1'b0;
				pend_o_nxt[i] = 1'b0;
				pend_on_nxt[i] = 1'b0;
				pend_off_nxt[i] = 1'b0;
			end
			code_nxt[i] = c;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < NCH; i++) code_r[i] <= cdsf_pkg::CDSF_ST_NOT_DONE;
			pend_b_r       <= '0;
			pend_g_r       <= '0;
			pend_o_r       <= '0;
			pend_on_r      <= '0;
			pend_off_r     <= '0;
			on_diag_start  <= '0;
			off_diag_start <= '0;
			uv_recover     <= 1'b0;
			core_active    <= 1'b0;
		end else begin
			for (int i = 0; i < NCH; i++) code_r[i] <= code_nxt[i];
			pend_b_r       <= pend_b_nxt;
			pend_g_r       <= pend_g_nxt;
			pend_o_r       <= pend_o_nxt;
			pend_on_r      <= pend_on_nxt;
			pend_off_r     <= pend_off_nxt;
			on_diag_start  <= ons_nxt;
			off_diag_start <= offs_nxt;
			uv_recover     <= uvr_nxt;
			core_active    <= live;
		end
	end

	// Output is the code array flattened; register-driven
	always_comb begin
		for (int i = 0; i < NCH; i++) status_code[3*i +: 3] = code_r[i];
	end
endmodule

// *** cdsf_top_properties.sv ***
// Purpose: Port-level timing checks of the channel status machine
// Assumes: Pins steady around each checked event
// Notes:   Channel 0 stands in for all channels
`timescale 1ns/10ps
module cdsf_top_chk #(
	parameter int NCH = 6
) (
	input wire logic             clk_sys,
	input wire logic             srst,
	input wire logic             master_reset_n,
	input wire logic             output_enable_n,
	input wire logic             load_supply_ok,
	input wire logic [NCH-1:0]   channel_parallel_input,
	input wire logic [NCH-1:0]   channel_serial_gate_bit,
	input wire logic [NCH-1:0]   latch_off_mode,
	input wire logic             status_read,
	input wire logic [NCH-1:0]   diag_done,
	input wire logic [NCH-1:0]   short_to_battery,
	input wire logic [NCH-1:0]   short_to_ground,
	input wire logic [3*NCH-1:0] status_code,
	input wire logic [NCH-1:0]   on_diag_start,
	input wire logic [NCH-1:0]   off_diag_start,
	input wire logic             uv_recover,
	input wire logic             core_active
);
	logic [2:0] c0;
	logic       rd;
	logic       go;
	assign c0 = status_code[2:0];
	assign rd = status_read && core_active;
	assign go = core_active && !status_read;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence s_cleared; c0 == 3'h7; endsequence
	sequence s_gnd_set; c0 == 3'h2; endsequence
	property p_rst; $fell(srst) |-> &status_code; endproperty
	property p_idle; !master_reset_n [*5] |-> &status_code && !core_active; endproperty
	property p_clr; rd && (c0 inside {[3'h2:3'h6]} || c0 == 3'h1 && !latch_off_mode[0])
		|=> s_cleared; endproperty
	property p_glo; rd && c0 == 3'h1 && latch_off_mode[0] |=> c0 == 3'h0; endproperty
	property p_hold; go && c0 == 3'h1 |=> c0 inside {3'h1, 3'h7}; endproperty
	property p_batt; go && diag_done[0] && short_to_battery[0] && !(c0 inside {3'h0, 3'h7})
		|=> c0 == 3'h1; endproperty
	// Read wins the cycle; the fault lands one cycle later
	property p_col; rd && diag_done[0] && short_to_ground[0] && !short_to_battery[0]
		&& !output_enable_n && load_supply_ok && c0 inside {[3'h3:3'h6]}
		|=> s_cleared ##1 s_gnd_set; endproperty
	property p_on; core_active && !output_enable_n && $rose(channel_parallel_input[0])
		&& !channel_serial_gate_bit[0] |-> ##[2:5] on_diag_start[0]; endproperty
	property p_off; core_active && !output_enable_n && load_supply_ok
		&& $fell(channel_parallel_input[0]) && !channel_serial_gate_bit[0]
		|-> ##[2:5] off_diag_start[0]; endproperty
	property p_uvr; core_active && $rose(load_supply_ok) |-> ##[2:4] uv_recover; endproperty
	a_rst: assert property (p_rst) else $error("code not 111 after reset");
	a_idle: assert property (p_idle) else $error("core not idle");
	a_clr: assert property (p_clr) else $error("read did not clear");
	a_glo: assert property (p_glo) else $error("no latched-off code");
	a_hold: assert property (p_hold) else $error("battery short demoted");
	a_batt: assert property (p_batt) else $error("battery short not coded");
	a_col: assert property (p_col) else $error("read and fault order");
	a_on: assert property (p_on) else $error("no on-state start");
	a_off: assert property (p_off) else $error("no off-state start");
	a_uvr: assert property (p_uvr) else $error("no supply recovery pulse");
endmodule
bind cdsf_top cdsf_top_chk #(.NCH(NCH)) chk_u (.*);

// *** cdsf_host_model.sv ***
// Purpose: Host that issues status reads and views channel codes
// Assumes: Read requests come from the bench
// Notes:   Unused channels are shown as not complete
`timescale 1ns/10ps
module cdsf_host_model #(
	parameter int NCH = 6
) (
	input  wire logic             clk_sys,
	input  wire logic             rd_go,
	input  wire logic [NCH-1:0]   used_mask,
	input  wire logic [3*NCH-1:0] status_code,
	output logic                  status_read,
	output logic      [3*NCH-1:0] seen_code
);
	initial status_read = 1'b0;
	always @(posedge clk_sys) status_read <= rd_go;
	// Fault data of idle channels means nothing to software
	always_comb for (int i = 0; i < NCH; i++)
		seen_code[3*i+:3] = used_mask[i] ? status_code[3*i+:3] : 3'h7;
endmodule

// *** cdsf_top_bench.sv ***
// Purpose: Self-checking bench of the channel status machine
// Assumes: Results arrive as diag_done pulses
// Notes:   Channel 0 latch-off, channel 5 unused
`timescale 1ns/10ps
module cdsf_top_bench;
	logic clk_sys = 1'b0, srst = 1'b1, por_ok = 1'b1, master_reset_n = 1'b1, rd_go = 1'b0;
	logic output_enable_n = 1'b0, load_supply_ok = 1'b1, probe = 1'b0;
	logic status_read, uv_recover, core_active;
	logic [5:0] channel_parallel_input = 6'h00, channel_serial_gate_bit = 6'h00;
	logic [5:0] on_pulse_req = 6'h00, off_pulse_req = 6'h00, unlatch = 6'h00;
	logic [5:0] diag_done = 6'h00, short_to_battery, short_to_ground, open_load_fault;
	logic [5:0] on_clean, off_clean, on_diag_start, off_diag_start;
	logic [5:0] latch_off_mode = 6'h01, used_mask = 6'h1F;
	logic [17:0] status_code, seen_code, q[$];
	logic [2:0] exp_c[6];
	int err_count = 0, comparisons = 0, cyc = 0, k, n, r[6];
	cdsf_top #(.NCH(6)) dut_u (.*);
	cdsf_host_model #(.NCH(6)) host_u (.*);
	always #4 clk_sys = ~clk_sys;
	task automatic report_and_stop();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic step(input int c);
		repeat (c) @(negedge clk_sys);
	endtask
	task automatic cmp(input logic [17:0] seen, input logic [17:0] want);
		comparisons++;
		if (seen !== want) begin
			err_count++;
			$display("wrong value status view exp %h seen %h", want, seen);
		end
	endtask
	task automatic chk();
		logic [17:0] w;
		for (int i = 0; i < 6; i++) w[3*i+:3] = used_mask[i] ? exp_c[i] : 3'h7;
		q.push_back(w);
		probe = 1'b1;
		step(1);
		probe = 1'b0;
	endtask
	function automatic logic [2:0] nx(input logic [2:0] c, input int v);
		logic [2:0] f;
		f = (v < 3) ? 3'(v + 1) : ((v == 3) ? 3'h5 : 3'h6);
		if (v < 3) return (c > 3'h3 || f < c) ? f : c;
		if (c == 3'h7) return f;
		return (c > 3'h3 && c != f) ? 3'h4 : c;
	endfunction
	task automatic apply(input bit upd);
		for (int i = 0; i < 6; i++) begin
			{off_clean[i], on_clean[i], open_load_fault[i], short_to_ground[i],
				short_to_battery[i]} = 5'h01 << r[i];
			if (upd) exp_c[i] = nx(exp_c[i], r[i]);
		end
		diag_done = 6'h3F;
		step(1);
		diag_done = 6'h00;
		step(2);
	endtask
	task automatic rd(input int gap);
		rd_go = 1'b1;
		step(1);
		rd_go = 1'b0;
		for (int i = 0; i < 6; i++)
			if (exp_c[i] == 3'h1 && latch_off_mode[i]) exp_c[i] = 3'h0;
			else if (exp_c[i] != 3'h0) exp_c[i] = 3'h7;
		step(gap);
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (probe) cmp(seen_code, q.pop_front());
		if (cyc == 3000) begin
			err_count++;
			report_and_stop();
		end
	end
	initial begin
		void'($urandom(32'h108793A2));
		for (k = 0; k < 6; k++) exp_c[k] = 3'h7;
		step(20);
		srst = 1'b0;
		for (n = 0; n < 20 && core_active !== 1'b1; n++) step(1);
		chk();
		for (n = 0; n < 6; n++) begin
			for (k = 0; k < 6; k++) r[k] = (n < 3 && k == 0) ? 0 : int'($urandom_range(4));
			apply(1);
			chk();
			if (n == 2) rd(2);
			if (n == 2) chk();
		end
		rd(2);
		on_pulse_req = 6'h01;
		step(1);
		on_pulse_req = 6'h00;
		step(2);
		exp_c[0] = 3'h7;
		chk();
		for (k = 0; k < 6; k++) r[k] = 3;
		apply(1);
		rd(0);
		for (k = 0; k < 6; k++) r[k] = 1;
		apply(1);
		chk();
		master_reset_n = 1'b0;
		step(7);
		for (k = 0; k < 6; k++) exp_c[k] = 3'h7;
		chk();
		master_reset_n = 1'b1;
		load_supply_ok = 1'b0;
		step(8);
		apply(0);
		chk();
		load_supply_ok = 1'b1;
		for (n = 0; n < 8; n++) begin
			channel_parallel_input = 6'($urandom);
			step(7);
		end
		report_and_stop();
	end
endmodule
